// *** pis_flame_model.sv ***
// Purpose: Far-side model of the burner flame seen by the sequencer
// Assumes: Flame can only exist while pilot gas flows
// Notes:   Lightoff delay and blow-out are steered by the bench
`timescale 1ns/1ps
module pis_flame_model (
    input  wire logic       mclk,      // System clock
    input  wire logic       pilot_on,  // Pilot gas from sequencer
    input  wire logic       light_en,  // Pilot lights when gas flows
    input  wire logic       blow,      // Knock the flame out
    input  wire logic [7:0] light_dly, // Gas cycles before lightoff
    output logic            flame      // Flame sense to sequencer
);
    int gas_cnt;

    initial begin
        flame   = 1'b0;
        gas_cnt = 0;
    end

    // ==========================================================
    // Flame follows gas; no gas or a draught puts it out at once
    always @(posedge mclk) begin
        if (!pilot_on || blow) begin
            gas_cnt <= 0;
            flame   <= 1'b0;
        end else begin
            gas_cnt <= gas_cnt + 1;
            flame   <= light_en && (gas_cnt >= int'(light_dly));
        end
    end
endmodule

// *** pis_pkg.sv ***
// Purpose: Shared constants and types for the pilot ignition sequencer
// Assumes: 100 MHz clock, register word per 32-bit aligned address
// Notes:   Cycle counts are derived from times in seconds
package pis_pkg;
    // ==========================================================
    // Timing
    localparam int             TW            = 36;
    localparam longint         CLK_HZ        = 64'd100_000_000;
    localparam longint         PREPURGE_S    = 64'd30;
    localparam longint         TRIAL_SHORT_S = 64'd15;
    localparam longint         TRIAL_LONG_S  = 64'd90;
    localparam longint         RETRY_MIN     = 64'd5;
    localparam logic [TW-1:0]  PREPURGE_CYC  = TW'(PREPURGE_S * CLK_HZ);
    localparam logic [TW-1:0]  TRIAL_S_CYC   = TW'(TRIAL_SHORT_S * CLK_HZ);
    localparam logic [TW-1:0]  TRIAL_L_CYC   = TW'(TRIAL_LONG_S * CLK_HZ);
    localparam logic [TW-1:0]  RETRY_CYC     = TW'(RETRY_MIN * 60 * CLK_HZ);
    localparam logic [1:0]     STRAP_WAIT    = 2'h3;

    // ==========================================================
    // Register map
    localparam logic [7:0]     CTRL_OFS      = 8'h00;
    localparam logic [7:0]     STATUS_OFS    = 8'h04;
    localparam logic [7:0]     IRQ_STAT_OFS  = 8'h08;
    localparam logic [7:0]     IRQ_EN_OFS    = 8'h0C;
    localparam logic [7:0]     IRQ_CLR_OFS   = 8'h10;
    localparam logic           CTRL_RST      = 1'h1;
    localparam int             NEV           = 4;
    localparam logic [NEV-1:0] IRQ_EN_RST    = 4'h0;
    // Event bits
    localparam int             EV_LIGHT      = 0;
    localparam int             EV_FAIL       = 1;
    localparam int             EV_LOST       = 2;
    localparam int             EV_DAMPER     = 3;
    // Status fields
    localparam int             ST_STATE      = 0;
    localparam int             ST_DAMP_REQ   = 4;
    localparam int             ST_FLAME      = 5;
    localparam int             ST_SPARK      = 6;
    localparam int             ST_PILOT      = 7;
    localparam int             ST_MAIN       = 8;

    typedef enum logic [2:0] {
        PIS_IDLE,
        PIS_PREPURGE,
        PIS_TRIAL,
        PIS_RUN,
        PIS_RETRY
    } pis_state_t;
endpackage

// *** pis_timer.sv ***
// Purpose: Down-counting interval timer for sequencer phases
// Assumes: len is at least one cycle
// Notes:   done pulses in the len-th cycle after the start edge
`timescale 1ns/1ps
module pis_timer (
    input  wire logic mclk,       // System clock
    input  wire logic rst,        // Synchronous reset
    pis_tmr_if.tmr    t           // Timer control
);
    logic [pis_pkg::TW-1:0] cnt_reg;
    logic [pis_pkg::TW-1:0] cnt_next;
    logic                   busy_reg;
    logic                   busy_next;
    wire                    last = busy_reg && cnt_reg == 36'h1;

    // ==========================================================
    // Counter; a fresh start wins over stop and expiry
    assign cnt_next  = t.start ? t.len :
                       busy_reg ? cnt_reg - 36'h1 : cnt_reg;
    assign busy_next = t.start ? 1'b1 :
                       (t.stop || last) ? 1'b0 : busy_reg;
    // Expiry comes from the count alone: gating it with start or stop
    // would loop back through the sequencer's next-state decode
    assign t.done    = last;
    assign t.busy    = busy_reg;

    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_reg  <= '0;
            busy_reg <= 1'b0;
        end else begin
            cnt_reg  <= cnt_next;
            busy_reg <= busy_next;
        end
    end
endmodule

// *** pis_tmr_if.sv ***
// Purpose: Carrier between the sequencer and its interval timer
// Assumes: Single clock domain
// Notes:   start is a one-cycle pulse, done a one-cycle pulse
`timescale 1ns/1ps
interface pis_tmr_if;
    logic                     start;
    logic                     stop;
    logic [pis_pkg::TW-1:0]   len;
    logic                     done;
    logic                     busy;
    modport ctl (output start, output stop, output len,
                 input done, input busy);
    modport tmr (input start, input stop, input len,
                 output done, output busy);
endinterface

// *** pis_top.sv ***
// Purpose: Intermittent pilot ignition sequencer with APB registers
// Assumes: Field pins are asynchronous; 100 MHz mclk
// Notes:   Strap for the damper is taken once after reset release
// Functional notes
// - Prepurge skipped or 30 s, by switch
// - Trial lasts 15 or 90 s, by switch
// - Spark and pilot on throughout trial
// - Flame loss restarts trial at once
// - Failed trial shuts pilot and spark off
// - Five minute wait, then new trial
// - Fail and retry repeats without limit
// - Damper seen at power-up becomes required
`timescale 1ns/1ps
module pis_top #(
    parameter logic [35:0] PREPURGE_CYC = pis_pkg::PREPURGE_CYC, // Prepurge
    parameter logic [35:0] TRIAL_S_CYC  = pis_pkg::TRIAL_S_CYC,  // Short
    parameter logic [35:0] TRIAL_L_CYC  = pis_pkg::TRIAL_L_CYC,  // Long
    parameter logic [35:0] RETRY_CYC    = pis_pkg::RETRY_CYC     // Retry
) (
    input  wire logic        mclk,                         // 100 MHz
    input  wire logic        rst,                          // Sync reset
    input  wire logic        psel,                         // APB select
    input  wire logic        penable,                      // APB enable
    input  wire logic        pwrite,                       // APB write
    input  wire logic [7:0]  paddr,                        // APB address
    input  wire logic [31:0] pwdata,                       // APB wdata
    output logic      [31:0] prdata,                       // APB rdata
    output logic             pready,                       // APB ready
    output logic             pslverr,                      // APB error
    input  wire logic        call_for_heat,                // Thermostat
    input  wire logic        flame_sense,                  // Flame seen
    input  wire logic        damper_present,               // Damper sense
    input  wire logic        prepurge_select_switch,       // 1: prepurge
    input  wire logic        trial_duration_select_switch, // 1: 90 s
    output logic             spark_out,                    // Igniter
    output logic             pilot_valve_out,              // Pilot gas
    output logic             main_valve_out,               // Main gas
    output logic             irq                           // Interrupt
);
    localparam int TW = pis_pkg::TW;
    localparam int NV = pis_pkg::NEV;

    // ==========================================================
    // Pin synchronisers
    logic [4:0] sync_a_reg;
    logic [4:0] sync_b_reg;
    wire        cfh_s    = sync_b_reg[0];
    wire        flame_s  = sync_b_reg[1];
    wire        damper_s = sync_b_reg[2];
    wire        pp_sw_s  = sync_b_reg[3];
    wire        tl_sw_s  = sync_b_reg[4];

    always_ff @(posedge mclk) begin
        if (rst) begin
            sync_a_reg <= '0;
            sync_b_reg <= '0;
        end else begin
            sync_a_reg <= {trial_duration_select_switch,
                           prepurge_select_switch, damper_present,
                           flame_sense, call_for_heat};
            sync_b_reg <= sync_a_reg;
        end
    end

    // ==========================================================
    // Damper strap, caught once the synchronisers have settled
    logic [1:0] arm_reg;
    logic       strap_done_reg;
    logic       damp_req_reg;
    wire        strap_now = !strap_done_reg && arm_reg == pis_pkg::STRAP_WAIT;

    always_ff @(posedge mclk) begin
        if (rst) begin
            arm_reg        <= 2'h0;
            strap_done_reg <= 1'b0;
            damp_req_reg   <= 1'b0;
        end else begin
            if (!strap_done_reg)
                arm_reg <= arm_reg + 2'h1;
            if (strap_now) begin
                strap_done_reg <= 1'b1;
                damp_req_reg   <= damper_s;
            end
        end
    end

    // ==========================================================
    // Registers
    logic          ctrl_en_reg;
    logic [NV-1:0] irq_stat_reg;
    logic [NV-1:0] irq_en_reg;
    logic [31:0]   prdata_reg;
    wire           damp_fault = damp_req_reg && !damper_s;
    // Heat call is honoured only with a settled strap and enable set
    wire           run_ok     = cfh_s && ctrl_en_reg && strap_done_reg
                                && !damp_fault;

    // ==========================================================
    // Sequencer
    pis_pkg::pis_state_t state_reg;
    pis_pkg::pis_state_t state_next;
    logic                long_sel_reg;
    pis_tmr_if           tif ();

    pis_timer u_timer (
        .mclk (mclk),
        .rst  (rst),
        .t    (tif.tmr)
    );

    wire trial_fail = state_reg == pis_pkg::PIS_TRIAL && tif.done
                      && !flame_s;
    wire flame_lost = state_reg == pis_pkg::PIS_RUN && !flame_s;
    wire lightoff   = state_reg == pis_pkg::PIS_TRIAL && flame_s;
    wire [TW-1:0] trial_len = long_sel_reg ? TRIAL_L_CYC
                                           : TRIAL_S_CYC;

    always_comb begin
        state_next = state_reg;
        if (!run_ok) begin
            state_next = pis_pkg::PIS_IDLE;
        end else begin
            unique case (state_reg)
                pis_pkg::PIS_IDLE: begin
                    state_next = pp_sw_s ? pis_pkg::PIS_PREPURGE
                                         : pis_pkg::PIS_TRIAL;
                end
                pis_pkg::PIS_PREPURGE: begin
                    if (tif.done)
                        state_next = pis_pkg::PIS_TRIAL;
                end
                pis_pkg::PIS_TRIAL: begin
                    if (flame_s)
                        state_next = pis_pkg::PIS_RUN;
                    else if (tif.done)
                        state_next = pis_pkg::PIS_RETRY;
                end
                pis_pkg::PIS_RUN: begin
                    if (!flame_s)
                        state_next = pis_pkg::PIS_TRIAL;
                end
                pis_pkg::PIS_RETRY: begin
                    if (tif.done)
                        state_next = pis_pkg::PIS_TRIAL;
                end
            endcase
        end
    end

    // Timer starts on entry to every timed phase, including RUN->TRIAL
    wire enter = state_next != state_reg;
    assign tif.start = enter && (state_next == pis_pkg::PIS_PREPURGE ||
                                 state_next == pis_pkg::PIS_TRIAL ||
                                 state_next == pis_pkg::PIS_RETRY);
    assign tif.stop  = enter && !tif.start;
    wire   long_use  = state_reg == pis_pkg::PIS_IDLE ? tl_sw_s
                                                      : long_sel_reg;
    assign tif.len   = state_next == pis_pkg::PIS_PREPURGE ? PREPURGE_CYC :
                       state_next == pis_pkg::PIS_RETRY ? RETRY_CYC :
                       long_use ? TRIAL_L_CYC : TRIAL_S_CYC;

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg       <= pis_pkg::PIS_IDLE;
            long_sel_reg    <= 1'b0;
            spark_out       <= 1'b0;
            pilot_valve_out <= 1'b0;
            main_valve_out  <= 1'b0;
        end else begin
            state_reg       <= state_next;
            long_sel_reg    <= long_use;
            // Outputs follow the next state so they switch with it
            spark_out       <= state_next == pis_pkg::PIS_TRIAL;
            pilot_valve_out <= state_next == pis_pkg::PIS_TRIAL ||
                               state_next == pis_pkg::PIS_RUN;
            main_valve_out  <= state_next == pis_pkg::PIS_RUN;
        end
    end

    // ==========================================================
    // APB slave: zero wait states, read data captured in setup
    // Ready is tied high, so every access completes in two cycles, setup and access
    wire setup   = psel && !penable;
    wire wr_acc  = psel && penable && pwrite;
    wire hit_ctl = paddr == pis_pkg::CTRL_OFS;
    wire hit_st  = paddr == pis_pkg::STATUS_OFS;
    wire hit_is  = paddr == pis_pkg::IRQ_STAT_OFS;
    wire hit_ie  = paddr == pis_pkg::IRQ_EN_OFS;
    wire hit_ic  = paddr == pis_pkg::IRQ_CLR_OFS;
    wire mapped  = hit_ctl || hit_st || hit_is || hit_ie || hit_ic;

    wire [31:0] status_word = {23'h0, main_valve_out, pilot_valve_out,
                               spark_out, flame_s, damp_req_reg,
                               1'b0, state_reg};
    wire [31:0] rd_mux = hit_ctl ? {31'h0, ctrl_en_reg} :
                         hit_st  ? status_word :
                         hit_is  ? {28'h0, irq_stat_reg} :
                         hit_ie  ? {28'h0, irq_en_reg} : 32'h0;

    wire [NV-1:0] ev;
    assign ev[pis_pkg::EV_LIGHT]  = lightoff;
    assign ev[pis_pkg::EV_FAIL]   = trial_fail;
    assign ev[pis_pkg::EV_LOST]   = flame_lost && run_ok;
    assign ev[pis_pkg::EV_DAMPER] = damp_fault && cfh_s;
    wire [NV-1:0] clr = (wr_acc && hit_ic) ? pwdata[NV-1:0] : '0;
    // A new event in the clearing cycle survives the clear
    wire [NV-1:0] irq_stat_next = (irq_stat_reg & ~clr) | ev;

    always_ff @(posedge mclk) begin
        if (rst) begin
            ctrl_en_reg  <= pis_pkg::CTRL_RST;
            irq_en_reg   <= pis_pkg::IRQ_EN_RST;
            irq_stat_reg <= '0;
            prdata_reg   <= 32'h0;
        end else begin
            if (wr_acc && hit_ctl)
                ctrl_en_reg <= pwdata[0];
            if (wr_acc && hit_ie)
                irq_en_reg <= pwdata[NV-1:0];
            irq_stat_reg <= irq_stat_next;
            if (setup)
                prdata_reg <= rd_mux;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign irq     = |(irq_stat_reg & irq_en_reg);

    // ==========================================================
    // Checks
    // Cycles spent in the current state, read only by the checks
    logic [TW-1:0] dwell_reg;
    always_ff @(posedge mclk) begin
        if (rst)
            dwell_reg <= '0;
        else
            dwell_reg <= enter ? '0 : dwell_reg + 36'h1;
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    prepurge_len_a: assert property (
        state_reg == pis_pkg::PIS_PREPURGE && run_ok &&
        state_next == pis_pkg::PIS_TRIAL |-> dwell_reg == PREPURGE_CYC - 36'h1)
        else $error("prepurge length wrong");

    trial_len_a: assert property (
        state_reg == pis_pkg::PIS_TRIAL &&
        state_next == pis_pkg::PIS_RETRY |-> dwell_reg == trial_len - 36'h1)
        else $error("trial length wrong");

    trial_outs_a: assert property (
        state_reg == pis_pkg::PIS_TRIAL |-> spark_out && pilot_valve_out)
        else $error("spark or pilot off in trial");

    flame_loss_a: assert property (
        state_reg == pis_pkg::PIS_RUN && !flame_s && run_ok
        |=> state_reg == pis_pkg::PIS_TRIAL && spark_out && dwell_reg == '0)
        else $error("flame loss did not restart trial");

    shutoff_a: assert property (
        state_reg == pis_pkg::PIS_RETRY |->
        !spark_out && !pilot_valve_out && !main_valve_out)
        else $error("gas not shut off after failed trial");

    prepurge_off_a: assert property (
        state_reg == pis_pkg::PIS_PREPURGE |->
        !spark_out && !pilot_valve_out && !main_valve_out)
        else $error("gas on during prepurge");

    retry_wait_a: assert property (
        state_reg == pis_pkg::PIS_RETRY && state_next == pis_pkg::PIS_TRIAL
        |-> dwell_reg == RETRY_CYC - 36'h1)
        else $error("retry wait length wrong");

    retry_loop_a: assert property (
        trial_fail && run_ok |=> state_reg == pis_pkg::PIS_RETRY
        && irq_stat_reg[pis_pkg::EV_FAIL])
        else $error("failed trial did not enter retry");

    damper_req_a: assert property (
        strap_done_reg && damp_req_reg && !damper_s
        |=> state_reg == pis_pkg::PIS_IDLE && !pilot_valve_out)
        else $error("ran without required damper");

    strap_hold_a: assert property (
        strap_done_reg |=> strap_done_reg && $stable(damp_req_reg))
        else $error("damper requirement changed after strap");

    main_valve_a: assert property (
        main_valve_out |-> $past(flame_s) && state_reg == pis_pkg::PIS_RUN)
        else $error("main valve open without flame");

    main_drop_a: assert property (
        main_valve_out && !flame_s |=> !main_valve_out)
        else $error("main valve held after flame loss");

    heat_off_a: assert property (
        !cfh_s |=> !spark_out && !pilot_valve_out && !main_valve_out
        && state_reg == pis_pkg::PIS_IDLE)
        else $error("outputs on without heat call");
endmodule

// *** pis_top_tb.sv ***
// Purpose: Self-checking bench for the pilot ignition sequencer
// Assumes: Shortened phase counts; APB master waits on pready
// Notes:   Phase lengths are measured on the spark and valve outputs
`timescale 1ns/1ps
module pis_top_tb;
    localparam logic [35:0] PP = 36'h14;
    localparam logic [35:0] TS = 36'hA;
    localparam logic [35:0] TL = 36'h1E;
    localparam logic [35:0] RT = 36'h28;
    logic        mclk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        heat, flame, damper, pp_sw, td_sw, err, light_en, blow;
    logic        spark, pilot, main_v, irq;
    int          miscompares, cmp_count, n, l0, l1;

    pis_top #(.PREPURGE_CYC(PP), .TRIAL_S_CYC(TS), .TRIAL_L_CYC(TL),
              .RETRY_CYC(RT)) u_dut (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .call_for_heat(heat), .flame_sense(flame),
        .damper_present(damper), .prepurge_select_switch(pp_sw),
        .trial_duration_select_switch(td_sw), .spark_out(spark),
        .pilot_valve_out(pilot), .main_valve_out(main_v), .irq(irq));

    pis_flame_model u_far (.mclk(mclk), .pilot_on(pilot),
        .light_en(light_en), .blow(blow), .light_dly(8'h05),
        .flame(flame));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // ==========================================================
    // Tasks
    task automatic finish_test();
        $display("Compares %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [35:0] seen, input logic [35:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask

    // One APB transfer; result lands in rd and err
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) begin
            miscompares++;
            $display("Error at %0t: APB answer timed out", $time);
            finish_test();
        end
    endtask

    // Count edges until output idx (0 spark, 1 pilot, 2 main) equals val
    task automatic wait_for(input int idx, input logic val, output int c);
        logic [2:0] o;
        c = 0;
        o = {main_v, pilot, spark};
        while (o[idx] !== val && c < 2000) begin
            @(posedge mclk);
            #1;
            c++;
            o = {main_v, pilot, spark};
        end
        if (c >= 2000) begin
            miscompares++;
            $display("Error at %0t: output %0d wait timed out", $time, idx);
            finish_test();
        end
    endtask

    task automatic set_heat(input logic v);
        @(posedge mclk);
        heat <= v;
        #1;
    endtask

    task automatic do_reset();
        @(posedge mclk);
        rst <= 1'b1;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        repeat (6) @(posedge mclk);
    endtask

    // ==========================================================
    // Scenarios
    initial begin
        {rst, psel, penable, pwrite, heat, damper} = 6'h21;
        {pp_sw, td_sw, light_en, blow, paddr, pwdata} = '0;
        miscompares = 0;
        cmp_count   = 0;
        damper      = 1'b0;
        do_reset();
        check({spark, pilot, main_v, irq}, 4'h0);
        apb(0, pis_pkg::CTRL_OFS, 0);
        check(rd, 32'h1);
        apb(0, pis_pkg::IRQ_EN_OFS, 0);
        check(rd, 32'h0);
        apb(0, pis_pkg::STATUS_OFS, 0);
        check(rd[4], 1'b0);
        apb(0, 8'h20, 0);
        check({err, rd}, 33'h100000000);
        apb(1, pis_pkg::IRQ_EN_OFS, 32'hF);
        set_heat(1);
        wait_for(0, 1, l0);
        check(pilot, 1'b1);
        wait_for(0, 0, n);
        check(n, TS);
        check(pilot, 1'b0);
        wait_for(0, 1, n);
        check(n, RT);
        wait_for(0, 0, n);
        check(n, TS);
        wait_for(0, 1, n);
        check(n, RT);
        set_heat(0);
        wait_for(1, 0, n);
        check(n <= 3, 1'b1);
        apb(0, pis_pkg::IRQ_STAT_OFS, 0);
        check({irq, rd}, 33'h100000002);
        apb(1, pis_pkg::IRQ_EN_OFS, 32'h0);
        #1;
        check(irq, 1'b0);
        apb(1, pis_pkg::IRQ_EN_OFS, 32'hF);
        @(posedge mclk);
        {pp_sw, td_sw} <= 2'h3;
        repeat (3) @(posedge mclk);
        set_heat(1);
        wait_for(0, 1, l1);
        check(l1 - l0, PP);
        wait_for(0, 0, n);
        check(n, TL);
        set_heat(0);
        apb(1, pis_pkg::IRQ_CLR_OFS, 32'hF);
        apb(0, pis_pkg::IRQ_STAT_OFS, 0);
        check({irq, rd}, 33'h0);
        @(posedge mclk);
        {pp_sw, light_en} <= 2'h1;
        repeat (3) @(posedge mclk);
        set_heat(1);
        wait_for(2, 1, n);
        check({flame, spark, pilot}, 3'h5);
        apb(0, pis_pkg::STATUS_OFS, 0);
        check(rd, 32'h1A3);
        @(posedge mclk);
        blow <= 1'b1;
        @(posedge mclk);
        blow <= 1'b0;
        #1;
        wait_for(0, 1, n);
        check({n <= 4, main_v}, 2'h2);
        wait_for(2, 1, n);
        apb(0, pis_pkg::IRQ_STAT_OFS, 0);
        check(rd, 32'h5);
        set_heat(0);
        wait_for(2, 0, n);
        check({n <= 3, pilot}, 2'h2);
        apb(1, pis_pkg::CTRL_OFS, 32'h0);
        set_heat(1);
        repeat (30) @(posedge mclk);
        check({spark, pilot, main_v}, 3'h0);
        apb(1, pis_pkg::CTRL_OFS, 32'h1);
        wait_for(2, 1, n);
        set_heat(0);
        // Damper strap must be steady across reset release
        @(posedge mclk);
        damper <= 1'b1;
        do_reset();
        apb(0, pis_pkg::STATUS_OFS, 0);
        check(rd[4], 1'b1);
        apb(1, pis_pkg::IRQ_EN_OFS, 32'hF);
        damper <= 1'b0;
        set_heat(1);
        repeat (30) @(posedge mclk);
        check({spark, pilot, main_v}, 3'h0);
        apb(0, pis_pkg::IRQ_STAT_OFS, 0);
        check({irq, rd[3]}, 2'h3);
        damper <= 1'b1;
        wait_for(0, 1, n);
        check(n <= 8, 1'b1);
        finish_test();
    end
endmodule
